/* File: common/edcr_defines.svh */
// Purpose : Offsets, reset values, masks and field positions of the
//           extended display control bank
// Assumes : Indexed byte-wide register port
// Notes   : Definitions only
`ifndef EDCR_DEFINES_SVH
`define EDCR_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define EDCR_IDX_SWAP_HOLD    8'h54
`define EDCR_IDX_CURSOR       8'h55
`define EDCR_IDX_SYNC_DRIVE   8'h56
`define EDCR_IDX_WIN_CTRL     8'h58
`define EDCR_IDX_WIN_BASE_HI  8'h59
`define EDCR_IDX_WIN_BASE_LO  8'h5A
`define EDCR_IDX_GEN_OUT      8'h5C
`define EDCR_IDX_HORIZ_OVF    8'h5D
`define EDCR_IDX_VERT_OVF     8'h5E
`define EDCR_IDX_REFRESH_BUD  8'h60
`define EDCR_IDX_IMAGE_SWAP   8'h61
`define EDCR_IDX_FETCH_START  8'h63
`define EDCR_IDX_MISC_CTRL    8'h65

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EDCR_RST_BYTE         8'h00
`define EDCR_RST_WIN_CTRL     8'h10
`define EDCR_RST_WIN_BASE     16'h0000

// ----------------------------------------------------------------
// Writable bit masks (reserved bits read zero)
// ----------------------------------------------------------------
`define EDCR_MSK_FULL         8'hFF
`define EDCR_MSK_CURSOR       8'h10
`define EDCR_MSK_SYNC_DRIVE   8'h06
`define EDCR_MSK_WIN_CTRL     8'h93
`define EDCR_MSK_HORIZ_OVF    8'h7F
`define EDCR_MSK_VERT_OVF     8'h57
`define EDCR_MSK_IMAGE_SWAP   8'h60
`define EDCR_MSK_FETCH_START  8'h18

// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define EDCR_BIT_CURSOR_STYLE 4
`define EDCR_BIT_HSYNC_DRIVE  1
`define EDCR_BIT_VSYNC_DRIVE  2
`define EDCR_BIT_LINEAR_EN    4
`define EDCR_BIT_PRECHARGE    7
`define EDCR_BIT_HOLD_MSB     2
`define EDCR_SIZE_64K         2'b00
`define EDCR_SIZE_1M          2'b01
`define EDCR_SIZE_2M          2'b10
`define EDCR_LEGACY_BASE      16'hA000
`define EDCR_BE_ALL           4'b0000
`define EDCR_BE_LOW_WORD      4'b0011
`define EDCR_BE_HIGH_WORD     4'b1100
`define EDCR_FETCH_DLY_SHORT  3'h4
`define EDCR_FETCH_DLY_LONG   3'h6

`endif

/* File: common/edcr_pkg.sv */
// Purpose : Types of the extended display control bank
// Assumes : edcr_defines.svh for all figures
// Notes   : State of the bank is one packed struct
package edcr_pkg;

  // Byte lane arrangement applied to a host doubleword
  typedef enum logic [1:0] {
    EDCR_SWAP_NONE,
    EDCR_SWAP_WORD,
    EDCR_SWAP_DWORD
  } edcr_swap_e;

  // Horizontal and vertical timing overflow bits
  typedef struct packed {
    logic [6:0] horiz;
    logic [4:0] vert;
  } edcr_ovf_s;

  // Whole register and decode state
  typedef struct packed {
    logic [7:0]  index;
    logic [7:0]  swap_hold;
    logic [7:0]  cursor;
    logic [7:0]  sync_drive;
    logic [7:0]  win_ctrl;
    logic [15:0] win_base;
    logic [7:0]  gen_out;
    logic [7:0]  horiz_ovf;
    logic [7:0]  vert_ovf;
    logic [7:0]  refresh_bud;
    logic [7:0]  image_swap;
    logic [7:0]  fetch_start;
    logic [7:0]  misc_ctrl;
    logic [7:0]  rdata;
    edcr_swap_e  swap_sel;
    logic        hsync_o;
    logic        hsync_oe;
    logic        vsync_o;
    logic        vsync_oe;
    logic        win_hit;
    logic [21:0] mem_addr;
    logic        legacy_en;
    logic        hsync_prev;
    logic [2:0]  fetch_cnt;
    logic        fetch_busy;
    logic        fetch_go;
  } edcr_state_s;

endpackage

/* File: hw/edcr_regs.sv */
// Purpose : Extended display control register bank with host swap,
//           linear window decode, sync drive and fetch start logic
// Assumes : Single clock; inputs synchronous to clk
// Notes   : Registers reached through an index/data byte port
`timescale 1ns/1ps
`default_nettype none
`include "edcr_defines.svh"

// Overview of operation
// - General swap: 00 none, 01 word, 10 dword reverse, 11 byte enables.
// - In mode 11: 0000 reverse, 0011/1100 word swap, else no swap.
// - Six-bit memory hold limit; bit 2 is MSB, bits 7-3 the rest.
// - Cursor decode style bit selects first or alternate decoding.
// - Horizontal sync pin driven only when its drive bit is 1.
// - Vertical sync pin driven only when its drive bit is 1.
// - Window size 00 64K, 01 1M, 10 2M, 11 reserved.
// - 64K window unavailable while relocatable memory-mapped mode is on.
// - Linear enable blocks legacy A000 decode unless banked 64K at A000.
// - Precharge trim bit shortens precharge, lengthens low by half clock.
// - Base gives address 31-16; low bits ignored for 1M and 2M.
// - Base bits 31-23 shared with PCI base address register.
// - Banked 64K window: page field picks displayed 64K page.
// - Relocatable mode uses base 31-26 plus host offset.
// - Horizontal overflow supplies bit 8 and bit 6 extensions.
// - Vertical overflow supplies bit 10 extensions; 3,5,7 reserved.
// - Refresh fill budget in memory clocks, low priority only.
// - Image write swap: 00 none, 01 word, 10 dword, 11 reserved.
// - Fetch start: sync fall, total or value, sync rise plus 4 or 6.
// - Swap and hold register is read/write and resets to zero.
module edcr_regs
  import edcr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Indexed register port
  input  wire logic        io_index_wr,
  input  wire logic        io_data_wr,
  input  wire logic        io_data_rd,
  input  wire logic [7:0]  io_wdata,
  output var  logic [7:0]  io_rdata,
  output var  logic [7:0]  io_index,
  // PCI base address shared bits 31-23
  input  wire logic        pci_base_wr,
  input  wire logic [8:0]  pci_base_wdata,
  output var  logic [8:0]  pci_base_bits,
  // Host access to swap and decode
  input  wire logic        host_req,
  input  wire logic [31:0] host_addr,
  input  wire logic [3:0]  host_be,
  input  wire logic        host_linear,
  input  wire logic        host_image,
  input  wire logic [1:0]  linear_swap_mode,
  output var  edcr_swap_e  host_swap_sel,
  output var  logic        win_hit,
  output var  logic [21:0] win_mem_addr,
  output var  logic        legacy_a000_enable,
  // Companion controls from other registers
  input  wire logic        banking_enable,
  input  wire logic        mmio_reloc_enable,
  input  wire logic [5:0]  page_select,
  input  wire logic        fetch_value_enable,
  // Memory arbiter and DRAM controls
  output var  logic [5:0]  hold_limit,
  output var  logic [7:0]  refresh_fill_budget,
  output var  logic        precharge_trim,
  // Display controls
  output var  logic        cursor_decode_style,
  output var  edcr_ovf_s   timing_ovf,
  output var  logic [7:0]  general_out,
  output var  logic [7:0]  misc_ctrl,
  // Sync pins
  input  wire logic        hsync_int,
  input  wire logic        vsync_int,
  output var  logic        hsync_o,
  output var  logic        hsync_oe,
  output var  logic        vsync_o,
  output var  logic        vsync_oe,
  // Display FIFO fetch start
  input  wire logic        char_tick,
  input  wire logic        at_htotal,
  input  wire logic        at_fetch_value,
  output var  logic        fetch_start
);

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  edcr_state_s s_q;
  edcr_state_s s_d;
  logic [7:0]  wmask;
  logic [7:0]  rd_val;
  logic [1:0]  win_size;
  logic        hs_rise;

  // --------------------------------------------------------------
  // Register read mux and write masks
  // --------------------------------------------------------------
  always_comb begin
    wmask  = `EDCR_MSK_FULL;
    rd_val = 8'h00;
    case (s_q.index)
      `EDCR_IDX_SWAP_HOLD:   rd_val = s_q.swap_hold;
      `EDCR_IDX_CURSOR: begin
        wmask  = `EDCR_MSK_CURSOR;
        rd_val = s_q.cursor;
      end
      `EDCR_IDX_SYNC_DRIVE: begin
        wmask  = `EDCR_MSK_SYNC_DRIVE;
        rd_val = s_q.sync_drive;
      end
      `EDCR_IDX_WIN_CTRL: begin
        wmask  = `EDCR_MSK_WIN_CTRL;
        rd_val = s_q.win_ctrl;
      end
      `EDCR_IDX_WIN_BASE_HI: rd_val = s_q.win_base[15:8];
      `EDCR_IDX_WIN_BASE_LO: rd_val = s_q.win_base[7:0];
      `EDCR_IDX_GEN_OUT:     rd_val = s_q.gen_out;
      `EDCR_IDX_HORIZ_OVF: begin
        wmask  = `EDCR_MSK_HORIZ_OVF;
        rd_val = s_q.horiz_ovf;
      end
      `EDCR_IDX_VERT_OVF: begin
        wmask  = `EDCR_MSK_VERT_OVF;
        rd_val = s_q.vert_ovf;
      end
      `EDCR_IDX_REFRESH_BUD: rd_val = s_q.refresh_bud;
      `EDCR_IDX_IMAGE_SWAP: begin
        wmask  = `EDCR_MSK_IMAGE_SWAP;
        rd_val = s_q.image_swap;
      end
      `EDCR_IDX_FETCH_START: begin
        wmask  = `EDCR_MSK_FETCH_START;
        rd_val = s_q.fetch_start;
      end
      `EDCR_IDX_MISC_CTRL:   rd_val = s_q.misc_ctrl;
      default: begin
        wmask  = 8'h00;
        rd_val = 8'h00;
      end
    endcase
  end

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    win_size = s_q.win_ctrl[1:0];
    hs_rise  = hsync_int && !s_q.hsync_prev;

    // Index and data writes
    if (io_index_wr) begin
      s_d.index = io_wdata;
    end
    if (io_data_wr) begin
      case (s_q.index)
        `EDCR_IDX_SWAP_HOLD:   s_d.swap_hold = io_wdata;
        `EDCR_IDX_CURSOR:      s_d.cursor = io_wdata & wmask;
        `EDCR_IDX_SYNC_DRIVE:  s_d.sync_drive = io_wdata & wmask;
        `EDCR_IDX_WIN_CTRL:    s_d.win_ctrl = io_wdata & wmask;
        `EDCR_IDX_WIN_BASE_HI: s_d.win_base[15:8] = io_wdata;
        `EDCR_IDX_WIN_BASE_LO: s_d.win_base[7:0] = io_wdata;
        `EDCR_IDX_GEN_OUT:     s_d.gen_out = io_wdata;
        `EDCR_IDX_HORIZ_OVF:   s_d.horiz_ovf = io_wdata & wmask;
        `EDCR_IDX_VERT_OVF:    s_d.vert_ovf = io_wdata & wmask;
        `EDCR_IDX_REFRESH_BUD: s_d.refresh_bud = io_wdata;
        `EDCR_IDX_IMAGE_SWAP:  s_d.image_swap = io_wdata & wmask;
        `EDCR_IDX_FETCH_START: s_d.fetch_start = io_wdata & wmask;
        `EDCR_IDX_MISC_CTRL:   s_d.misc_ctrl = io_wdata;
        default: ;
      endcase
    end
    // Shared upper base bits, PCI path wins a same-cycle clash
    if (pci_base_wr) begin
      s_d.win_base[15:7] = pci_base_wdata;
    end
    if (io_data_rd) begin
      s_d.rdata = rd_val;
    end

    // Host byte swap selection
    if (host_req) begin
      if (host_image) begin
        case (s_q.image_swap[6:5])
          2'b01:   s_d.swap_sel = EDCR_SWAP_WORD;
          2'b10:   s_d.swap_sel = EDCR_SWAP_DWORD;
          default: s_d.swap_sel = EDCR_SWAP_NONE;
        endcase
      end else if (host_linear) begin
        case (linear_swap_mode)
          2'b01:   s_d.swap_sel = EDCR_SWAP_WORD;
          2'b10:   s_d.swap_sel = EDCR_SWAP_DWORD;
          default: s_d.swap_sel = EDCR_SWAP_NONE;
        endcase
      end else begin
        case (s_q.swap_hold[1:0])
          2'b00:   s_d.swap_sel = EDCR_SWAP_NONE;
          2'b01:   s_d.swap_sel = EDCR_SWAP_WORD;
          2'b10:   s_d.swap_sel = EDCR_SWAP_DWORD;
          default: begin
            case (host_be)
              `EDCR_BE_ALL:       s_d.swap_sel = EDCR_SWAP_DWORD;
              `EDCR_BE_LOW_WORD:  s_d.swap_sel = EDCR_SWAP_WORD;
              `EDCR_BE_HIGH_WORD: s_d.swap_sel = EDCR_SWAP_WORD;
              default:            s_d.swap_sel = EDCR_SWAP_NONE;
            endcase
          end
        endcase
      end
    end

    // Linear window decode
    s_d.win_hit  = 1'b0;
    s_d.mem_addr = 22'h000000;
    if (s_q.win_ctrl[`EDCR_BIT_LINEAR_EN]) begin
      if (mmio_reloc_enable) begin
        // Only base 31-26 compared; offset taken from host address
        s_d.win_hit  = host_addr[31:26] == s_q.win_base[15:10];
        s_d.mem_addr = host_addr[21:0];
      end else begin
        case (win_size)
          `EDCR_SIZE_64K: begin
            s_d.win_hit = host_addr[31:16] == s_q.win_base;
            if (banking_enable) begin
              s_d.mem_addr = {page_select, host_addr[15:0]};
            end else begin
              s_d.mem_addr = {6'h00, host_addr[15:0]};
            end
          end
          `EDCR_SIZE_1M: begin
            s_d.win_hit  = host_addr[31:20] == s_q.win_base[15:4];
            s_d.mem_addr = {2'b00, host_addr[19:0]};
          end
          `EDCR_SIZE_2M: begin
            s_d.win_hit  = host_addr[31:21] == s_q.win_base[15:5];
            s_d.mem_addr = {1'b0, host_addr[20:0]};
          end
          default: ;
        endcase
      end
    end
    s_d.legacy_en = !s_q.win_ctrl[`EDCR_BIT_LINEAR_EN] ||
                    (banking_enable && !mmio_reloc_enable &&
                     win_size == `EDCR_SIZE_64K &&
                     s_q.win_base == `EDCR_LEGACY_BASE);

    // Sync pin drive
    s_d.hsync_o  = hsync_int;
    s_d.vsync_o  = vsync_int;
    s_d.hsync_oe = s_q.sync_drive[`EDCR_BIT_HSYNC_DRIVE];
    s_d.vsync_oe = s_q.sync_drive[`EDCR_BIT_VSYNC_DRIVE];

    // Display FIFO fetch start
    s_d.hsync_prev = hsync_int;
    s_d.fetch_go   = 1'b0;
    case (s_q.fetch_start[4:3])
      2'b00: begin
        s_d.fetch_busy = 1'b0;
        s_d.fetch_go   = !hsync_int && s_q.hsync_prev;
      end
      2'b01: begin
        s_d.fetch_busy = 1'b0;
        s_d.fetch_go   = fetch_value_enable ? at_fetch_value : at_htotal;
      end
      default: begin
        if (hs_rise) begin
          s_d.fetch_busy = 1'b1;
          s_d.fetch_cnt  = s_q.fetch_start[3] ? `EDCR_FETCH_DLY_LONG
                                              : `EDCR_FETCH_DLY_SHORT;
        end else if (s_q.fetch_busy && char_tick) begin
          s_d.fetch_cnt = s_q.fetch_cnt - 3'h1;
          if (s_q.fetch_cnt == 3'h1) begin
            s_d.fetch_busy = 1'b0;
            s_d.fetch_go   = 1'b1;
          end
        end
      end
    endcase
  end

  // --------------------------------------------------------------
  // State register
  // --------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q          <= '0;
      s_q.win_ctrl <= `EDCR_RST_WIN_CTRL;
      s_q.win_base <= `EDCR_RST_WIN_BASE;
      s_q.swap_hold <= `EDCR_RST_BYTE;
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------
  // Outputs straight from state flops
  // --------------------------------------------------------------
  assign io_rdata            = s_q.rdata;
  assign io_index            = s_q.index;
  assign pci_base_bits       = s_q.win_base[15:7];
  assign host_swap_sel       = s_q.swap_sel;
  assign win_hit             = s_q.win_hit;
  assign win_mem_addr        = s_q.mem_addr;
  assign legacy_a000_enable  = s_q.legacy_en;
  assign hold_limit          = {s_q.swap_hold[`EDCR_BIT_HOLD_MSB],
                                s_q.swap_hold[7:3]};
  assign refresh_fill_budget = s_q.refresh_bud;
  assign precharge_trim      = s_q.win_ctrl[`EDCR_BIT_PRECHARGE];
  assign cursor_decode_style = s_q.cursor[`EDCR_BIT_CURSOR_STYLE];
  assign timing_ovf.horiz    = s_q.horiz_ovf[6:0];
  assign timing_ovf.vert     = {s_q.vert_ovf[6], s_q.vert_ovf[4],
                                s_q.vert_ovf[2:0]};
  assign general_out         = s_q.gen_out;
  assign misc_ctrl           = s_q.misc_ctrl;
  assign hsync_o             = s_q.hsync_o;
  assign hsync_oe            = s_q.hsync_oe;
  assign vsync_o             = s_q.vsync_o;
  assign vsync_oe            = s_q.vsync_oe;
  assign fetch_start         = s_q.fetch_go;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  swap_be_dword_a: assert property (@(posedge clk) disable iff (sys_rst)
    host_req && !host_image && !host_linear &&
    s_q.swap_hold[1:0] == 2'b11 && host_be == 4'b0000
    |=> host_swap_sel == EDCR_SWAP_DWORD)
    else $error("byte enable 0000 did not reverse doubleword");

  swap_general_a: assert property (@(posedge clk) disable iff (sys_rst)
    host_req && !host_image && !host_linear &&
    s_q.swap_hold[1:0] == 2'b01
    |=> host_swap_sel == EDCR_SWAP_WORD)
    else $error("general swap 01 did not select word swap");

  image_swap_a: assert property (@(posedge clk) disable iff (sys_rst)
    host_req && host_image && s_q.image_swap[6:5] == 2'b11
    |=> host_swap_sel == EDCR_SWAP_NONE)
    else $error("reserved image swap code did not give no swap");

  hold_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    io_data_wr && s_q.index == 8'h54
    |=> hold_limit == {$past(io_wdata[2]), $past(io_wdata[7:3])}
    ##1 ($past(io_data_wr) || hold_limit == $past(hold_limit)))
    else $error("hold limit not built from written byte");

  hsync_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
    io_data_wr && s_q.index == 8'h56 && !io_wdata[1] && !pci_base_wr
    |=> ##1 !hsync_oe)
    else $error("horizontal sync driven with drive bit clear");

  vsync_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
    io_data_wr && s_q.index == 8'h56 && io_wdata[2]
    |=> ##1 vsync_oe)
    else $error("vertical sync not driven with drive bit set");

  legacy_block_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.win_ctrl[4] && !banking_enable |=> !legacy_a000_enable)
    else $error("legacy region open while linear window enabled");

  reserved_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    io_data_rd && s_q.index == 8'h5E |=> io_rdata[7] == 1'b0 &&
    io_rdata[5] == 1'b0 && io_rdata[3] == 1'b0)
    else $error("reserved vertical overflow bit read nonzero");

  pci_share_a: assert property (@(posedge clk) disable iff (sys_rst)
    pci_base_wr |=> pci_base_bits == $past(pci_base_wdata))
    else $error("shared base bits not updated from PCI path");

  fetch_delay_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.fetch_start[4:3] == 2'b10 && hsync_int && !s_q.hsync_prev
    |=> s_q.fetch_cnt == 3'h4)
    else $error("fetch delay not loaded with four character clocks");

endmodule
`default_nettype wire

/* File: verif/edcr_host_model.sv */
// Purpose : Host model for the indexed register port and PCI base path
// Assumes : Requests start on the falling clock edge
// Notes   : Idle write data shows the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module edcr_host_model (
  // Clock
  input  wire logic       clk,
  // Register port
  output var  logic       io_index_wr,
  output var  logic       io_data_wr,
  output var  logic       io_data_rd,
  output var  logic [7:0] io_wdata,
  input  wire logic [7:0] io_rdata,
  // Shared base bits
  output var  logic       pci_base_wr,
  output var  logic [8:0] pci_base_wdata
);
  // Idle bus at time zero
  initial begin
    {io_index_wr, io_data_wr, io_data_rd, pci_base_wr} = 4'h0;
    io_wdata = 8'hA5;
    pci_base_wdata = 9'h0A5;
  end

  // One strobe held across one rising edge
  task automatic strobe_cycle(input logic [2:0] strb, input logic [7:0] val);
    @(negedge clk);
    {io_index_wr, io_data_wr, io_data_rd} = strb;
    io_wdata = val;
    @(negedge clk);
    {io_index_wr, io_data_wr, io_data_rd} = 3'h0;
    io_wdata = ~val;
  endtask

  // Index first, then the data write
  task automatic write_reg(input logic [7:0] idx, val);
    strobe_cycle(3'h4, idx);
    strobe_cycle(3'h2, val);
  endtask

  // Index, read strobe, then take the registered data
  task automatic read_reg(input logic [7:0] idx, output logic [7:0] val);
    strobe_cycle(3'h4, idx);
    strobe_cycle(3'h1, idx);
    @(negedge clk);
    val = io_rdata;
  endtask

  // Upper base bits through the configuration path
  task automatic pci_write(input logic [8:0] val);
    @(negedge clk);
    pci_base_wr = 1'b1;
    pci_base_wdata = val;
    @(negedge clk);
    pci_base_wr = 1'b0;
    pci_base_wdata = ~val;
  endtask
endmodule
`default_nettype wire

/* File: verif/edcr_regs_bench.sv */
// Purpose : Self-checking bench for the extended display control bank
// Assumes : Inputs change on the falling clock edge
// Notes   : Register traffic goes through the host model tasks
`timescale 1ns/1ps
`default_nettype none
module edcr_regs_bench;
  import edcr_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        io_index_wr, io_data_wr, io_data_rd, pci_base_wr;
  logic [7:0]  io_wdata, io_rdata, rv, refresh_fill_budget;
  logic [8:0]  pci_base_wdata, pci_base_bits;
  logic        host_req = 1'b0, host_image = 1'b0, host_linear = 1'b0;
  logic [31:0] host_addr = 32'h0;
  logic [3:0]  host_be = 4'h0;
  logic        banking_enable = 1'b0, mmio_reloc_enable = 1'b0;
  logic [5:0]  page_select = 6'h2A, hold_limit;
  logic        hsync_int = 1'b0, win_hit, legacy_a000_enable, fetch_start;
  logic        precharge_trim, cursor_decode_style, hsync_oe, vsync_oe;
  logic [21:0] win_mem_addr;
  logic [7:0]  io_index, general_out, misc_ctrl;
  logic [1:0]  linear_swap_mode = 2'h0;
  logic        fetch_value_enable = 1'b0;
  logic        at_htotal = 1'b0, at_fetch_value = 1'b0, hsync_o, vsync_o;
  edcr_swap_e  host_swap_sel;
  edcr_ovf_s   timing_ovf;
  int          err_total = 0;
  int          check_count = 0;
  int          n4, n6, nf;
  logic [7:0]  idx_t [14] = '{8'h54, 8'h55, 8'h56, 8'h58, 8'h59, 8'h5A,
    8'h5C, 8'h5D, 8'h5E, 8'h60, 8'h61, 8'h63, 8'h65, 8'h57};
  logic [7:0]  msk_t [14] = '{8'hFF, 8'h10, 8'h06, 8'h93, 8'hFF, 8'hFF,
    8'hFF, 8'h7F, 8'h57, 8'hFF, 8'h60, 8'h18, 8'hFF, 8'h00};
  logic [1:0]  sm [7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3};
  logic [3:0]  sb [7] = '{4'h5, 4'h5, 4'h5, 4'h0, 4'h3, 4'hC, 4'h5};
  logic [1:0]  se [7] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h1, 2'h1, 2'h0};
  logic [7:0]  wc [7] = '{8'h11, 8'h11, 8'h12, 8'h12, 8'h13, 8'h10, 8'h10};
  logic [31:0] wa [7] = '{32'h12300000, 32'h12400000, 32'h12200000,
    32'h12600000, 32'h12340000, 32'h12345678, 32'h12350000};
  logic        wh [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

  edcr_host_model edcr_host_model_inst (.clk(clk), .io_index_wr(io_index_wr),
    .io_data_wr(io_data_wr), .io_data_rd(io_data_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .pci_base_wr(pci_base_wr),
    .pci_base_wdata(pci_base_wdata));
  edcr_regs edcr_regs_inst (.clk(clk), .sys_rst(sys_rst),
    .io_index_wr(io_index_wr), .io_data_wr(io_data_wr),
    .io_data_rd(io_data_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_index(io_index), .pci_base_wr(pci_base_wr),
    .pci_base_wdata(pci_base_wdata),
    .pci_base_bits(pci_base_bits), .host_req(host_req),
    .host_addr(host_addr), .host_be(host_be), .host_linear(host_linear),
    .host_image(host_image), .linear_swap_mode(linear_swap_mode),
    .host_swap_sel(host_swap_sel), .win_hit(win_hit),
    .win_mem_addr(win_mem_addr), .legacy_a000_enable(legacy_a000_enable),
    .banking_enable(banking_enable), .mmio_reloc_enable(mmio_reloc_enable),
    .page_select(page_select), .fetch_value_enable(fetch_value_enable),
    .hold_limit(hold_limit), .refresh_fill_budget(refresh_fill_budget),
    .precharge_trim(precharge_trim),
    .cursor_decode_style(cursor_decode_style), .timing_ovf(timing_ovf),
    .general_out(general_out), .misc_ctrl(misc_ctrl), .hsync_int(hsync_int),
    .vsync_int(hsync_int), .hsync_o(hsync_o), .hsync_oe(hsync_oe),
    .vsync_o(vsync_o), .vsync_oe(vsync_oe), .char_tick(1'b1),
    .at_htotal(at_htotal), .at_fetch_value(at_fetch_value),
    .fetch_start(fetch_start));

  // 250 MHz clock
  always #2 clk = ~clk;

  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Register access shorthands
  task automatic wr(input logic [7:0] idx, val);
    edcr_host_model_inst.write_reg(idx, val);
  endtask
  task automatic rdc(input logic [7:0] idx, exp);
    edcr_host_model_inst.read_reg(idx, rv);
    chk($sformatf("reg %h", idx), {24'h0, rv}, {24'h0, exp});
  endtask

  // Host request, answer registered at the next edge
  task automatic hreq(input logic [3:0] be, input logic lin, img);
    @(negedge clk);
    host_req = 1'b1;
    host_be = be;
    host_linear = lin;
    host_image = img;
    @(negedge clk);
    host_req = 1'b0;
  endtask

  // Present one address for the window decoder
  task automatic dec(input logic [31:0] a);
    @(negedge clk);
    host_addr = a;
    @(negedge clk);
  endtask

  // Move the sync level, count cycles to the fetch pulse
  task automatic sync_to(input logic lvl, output int n);
    @(negedge clk);
    hsync_int = lvl;
    n = 0;
    while (n < 20 && fetch_start !== 1'b1) begin
      @(negedge clk);
      n++;
    end
  endtask

  // Counts and verdict
  task automatic finish_test();
    $display("Checks made %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #20000;
    err_total++;
    finish_test();
  end

  // Main sequence
  initial begin
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    chk("legacy", legacy_a000_enable, 1'b0);
    for (int i = 0; i < 14; i++) begin
      rdc(idx_t[i], (i == 3) ? 8'h10 : 8'h00);
      wr(idx_t[i], 8'hFF);
      rdc(idx_t[i], msk_t[i]);
      wr(idx_t[i], 8'h00);
    end
    wr(8'h54, 8'hAC);
    chk("hold", hold_limit, 6'h35);
    for (int i = 0; i < 7; i++) begin
      wr(8'h54, {6'b101011, sm[i]});
      hreq(sb[i], 1'b0, 1'b0);
      chk("swap", host_swap_sel, se[i]);
    end
    for (int m = 0; m < 4; m++) begin
      linear_swap_mode = m[1:0];
      wr(8'h61, {1'b0, m[1:0] + 2'h1, 5'h00});
      hreq(4'h5, 1'b1, 1'b0);
      chk("linear swap", host_swap_sel, m % 3);
      hreq(4'h5, 1'b1, 1'b1);
      chk("image swap", host_swap_sel, (m + 1) % 4 % 3);
    end
    wr(8'h56, 8'h06);
    repeat (2) @(negedge clk);
    chk("sync oe", {hsync_oe, vsync_oe}, 2'b11);
    wr(8'h56, 8'h04);
    repeat (2) @(negedge clk);
    chk("sync oe", {hsync_oe, vsync_oe}, 2'b01);
    wr(8'h59, 8'h12);
    wr(8'h5A, 8'h34);
    banking_enable = 1'b1;
    for (int i = 0; i < 7; i++) begin
      wr(8'h58, wc[i]);
      dec(wa[i]);
      chk("hit", win_hit, wh[i]);
    end
    dec(32'h12345678);
    chk("page addr", win_mem_addr, {6'h2A, 16'h5678});
    mmio_reloc_enable = 1'b1;
    dec(32'h13ABCDEF);
    chk("reloc hit", win_hit, 1'b1);
    chk("reloc addr", win_mem_addr, 22'h2BCDEF);
    mmio_reloc_enable = 1'b0;
    wr(8'h59, 8'hA0);
    wr(8'h5A, 8'h00);
    dec(32'h0);
    chk("legacy", legacy_a000_enable, 1'b1);
    banking_enable = 1'b0;
    dec(32'h0);
    chk("legacy", legacy_a000_enable, 1'b0);
    edcr_host_model_inst.pci_write(9'h1FF);
    chk("pci view", pci_base_bits, 9'h1FF);
    rdc(8'h59, 8'hFF);
    rdc(8'h5A, 8'h80);
    wr(8'h59, 8'h12);
    chk("pci view", pci_base_bits, 9'h025);
    wr(8'h58, 8'h90);
    chk("precharge", precharge_trim, 1'b1);
    wr(8'h55, 8'h10);
    chk("cursor", cursor_decode_style, 1'b1);
    wr(8'h60, 8'h5A);
    chk("budget", refresh_fill_budget, 8'h5A);
    wr(8'h5C, 8'h3C);
    wr(8'h65, 8'hC3);
    chk("out regs", {general_out, misc_ctrl, io_index}, 24'h3CC365);
    wr(8'h5D, 8'hD5);
    chk("horiz ovf", timing_ovf.horiz, 7'h55);
    wr(8'h5E, 8'h52);
    chk("vert ovf", timing_ovf.vert, 5'h1A);
    wr(8'h63, 8'h00);
    sync_to(1'b1, nf);
    sync_to(1'b0, nf);
    chk("fetch fall", nf, 1);
    wr(8'h63, 8'h10);
    sync_to(1'b1, n4);
    wr(8'h63, 8'h18);
    sync_to(1'b0, n6);
    chk("sync out", {hsync_o, vsync_o}, 2'b00);
    sync_to(1'b1, n6);
    chk("fetch seen", n4, 5);
    chk("fetch delay", n6 - n4, 2);
    wr(8'h63, 8'h08);
    chk("sync out", {hsync_o, vsync_o}, 2'b11);
    for (int v = 0; v < 2; v++) begin
      fetch_value_enable = v[0];
      for (int p = 1; p < 3; p++) begin
        @(negedge clk);
        {at_fetch_value, at_htotal} = p[1:0];
        @(negedge clk);
        {at_fetch_value, at_htotal} = 2'b00;
        chk("fetch mode 01", fetch_start, p[1] == v[0]);
      end
    end
    finish_test();
  end
endmodule
`default_nettype wire
